// *** csd_clock_synth.sv ***
// clock synthesiser: core clock, pci fan-out, memory, processor and
// feedback clocks, with memory-side clocks advanced by the loop
// assumes all inputs synchronous to clk; one step is one clk cycle
// Notes on behaviour
// R1: one input makes cpu, slave, memory, pci clocks
// R2: period split into 128 delay steps
// R3: drive feedback edge, count steps until echo
// R4: longer feedback makes memory clocks start earlier
// R5: only memory, cpu, feedback clocks shift
// R6: memory and cpu generation ignore host mode
// R7: host mode fan-out clocks agents and core
// R8: agent source drives core input directly
// R9: cpu clocks come from memory clock loop
// R10: lock only after measurement and hold
`timescale 1ns/1ps
`default_nettype none
module csd_clock_synth
   import csd_pkg::*;
#(
   parameter int unsigned STEPS  = csd_pkg::CSD_STEPS,
   parameter int unsigned STEP_W = csd_pkg::CSD_STEP_W
) (
   input  wire logic                        clk,
   input  wire logic                        rst_n,
   input  wire logic                        ce,
   input  wire logic                        host_mode,
   input  wire logic                        core_clock_input_alias,
   input  wire logic                        fb_in,
   output logic                             fb_out,
   output logic                             core_clk,
   output logic [csd_pkg::CSD_N_CPU-1:0]    cpu_clk,
   output logic [csd_pkg::CSD_N_MEM-1:0]    mem_clk,
   output logic [csd_pkg::CSD_N_PCI-1:0]    pci_clk,
   output logic [STEP_W-1:0]                delay_steps,
   output logic                             locked
);
   import csd_pkg::*;

   localparam logic [STEP_W-1:0] HALF     = STEP_W'(STEPS / 2);
   localparam logic [STEP_W-1:0] LAST     = STEP_W'(STEPS - 1);
   localparam int unsigned       HOLD_CYC = CSD_HOLD_PER * STEPS;
   localparam logic [STEP_W:0]   HOLD_END = (STEP_W + 1)'(HOLD_CYC - 1);

   generate
      if (STEPS != (1 << STEP_W) || STEPS < 4 ||
          CSD_HOLD_PER != 1) begin : g_chk
         $error("STEPS must be 2**STEP_W, at least 4");
      end
   endgenerate

   csd_meas_if #(.W(STEP_W)) mif ();

   csd_meas #(.W(STEP_W)) u_meas (
      .clk   (clk),
      .rst_n (rst_n),
      .ce    (ce),
      .fb_in (fb_in),
      .m     (mif)
   );

   csd_state_t        state;
   logic [STEP_W-1:0] phase;
   logic [STEP_W-1:0] delay;
   logic [STEP_W:0]   hold_cnt;
   logic              alias_prev;
   logic              measured;
   csd_state_t        next_state;
   logic [STEP_W-1:0] next_phase;
   logic [STEP_W-1:0] next_delay;
   logic [STEP_W:0]   next_hold_cnt;
   logic              next_measured;
   logic [STEP_W-1:0] shifted;
   logic              core_lvl;
   logic              shift_lvl;
   logic              next_alias_prev;
   logic              next_core_clk;
   logic              next_fb_out;
   logic [CSD_N_CPU-1:0] next_cpu_clk;
   logic [CSD_N_MEM-1:0] next_mem_clk;
   logic [CSD_N_PCI-1:0] next_pci_clk;
   logic [STEP_W-1:0] next_delay_steps;
   logic              next_locked;

   // advanced phase: memory side runs delay steps ahead of the core
   assign shifted   = STEP_W'(phase + delay);                  // see R4
   assign core_lvl  = (phase < HALF);                           // see R2
   assign shift_lvl = (shifted < HALF);                         // see R6
   // feedback edge leaves when the advanced phase wraps to zero
   assign mif.start = ce && (shifted == '0);                    // see R3

   always_comb begin
      next_state    = state;
      next_delay    = delay;
      next_hold_cnt = hold_cnt;
      next_measured = measured || mif.done;
      next_alias_prev = core_clock_input_alias;
      // core phase realigns to every rising edge of the core input
      if (core_clock_input_alias && !alias_prev) begin           // see R8
         next_phase = '0;
      end else begin
         next_phase = (phase == LAST) ? '0 : STEP_W'(phase + 1'b1);
      end
      unique case (state)
         CSD_ST_ACQ: begin
            if (mif.done) begin
               next_delay    = mif.steps;                        // see R4
               next_hold_cnt = '0;
               next_state    = CSD_ST_HOLD;
            end
         end
         CSD_ST_HOLD: begin
            // fresh results ignored so the applied delay settles a period
            if (hold_cnt == HOLD_END) begin                      // see R10
               next_state = CSD_ST_LOCK;
            end else begin
               next_hold_cnt = (STEP_W + 1)'(hold_cnt + 1'b1);
            end
         end
         CSD_ST_LOCK: begin
            if (mif.done) begin
               next_delay = mif.steps;                           // see R4
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state      <= CSD_ST_ACQ;
         phase      <= CSD_PHASE_RST;
         delay      <= CSD_DELAY_RST;
         hold_cnt   <= '0;
         alias_prev <= 1'b0;
         measured   <= 1'b0;
      end else if (ce) begin
         state      <= next_state;
         phase      <= next_phase;
         delay      <= next_delay;
         hold_cnt   <= next_hold_cnt;
         alias_prev <= next_alias_prev;
         measured   <= next_measured;
      end
   end

   // output stage: one register delay shared by all clocks, so the
   // relative phases are exact; host_mode reaches only the fan-out
   always_comb begin
      next_core_clk    = core_lvl;
      next_fb_out      = shift_lvl;                             // see R5
      next_mem_clk     = {CSD_N_MEM{shift_lvl}};                // see R1
      next_cpu_clk     = {CSD_N_CPU{shift_lvl}};                // see R9
      // agent mode leaves the fan-out idle: buffer skew avoided
      next_pci_clk     = host_mode ? {CSD_N_PCI{core_lvl}} : '0; // see R7
      next_delay_steps = delay;
      next_locked      = (state == CSD_ST_LOCK);                // see R10
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         core_clk    <= 1'b0;
         fb_out      <= 1'b0;
         cpu_clk     <= '0;
         mem_clk     <= '0;
         pci_clk     <= '0;
         delay_steps <= '0;
         locked      <= 1'b0;
      end else if (ce) begin
         core_clk    <= next_core_clk;
         fb_out      <= next_fb_out;
         mem_clk     <= next_mem_clk;
         cpu_clk     <= next_cpu_clk;
         pci_clk     <= next_pci_clk;
         delay_steps <= next_delay_steps;
         locked      <= next_locked;
      end
   end

   a_pci_core_sync: assert property ( // see R5
      @(posedge clk) disable iff (!rst_n)
      host_mode && ce |=> (pci_clk == {CSD_N_PCI{$past(core_lvl)}}))
      else $error("pci fan-out not on the core clock");
   a_agent_fanout_idle: assert property ( // see R7
      @(posedge clk) disable iff (!rst_n)
      !host_mode && ce |=> pci_clk == '0)
      else $error("fan-out active in agent mode");
   a_cpu_with_mem: assert property ( // see R9
      @(posedge clk) disable iff (!rst_n)
      cpu_clk == {CSD_N_CPU{mem_clk[0]}} && fb_out == mem_clk[0])
      else $error("cpu or feedback clock apart from memory");
   a_mem_lead: assert property ( // see R4
      @(posedge clk) disable iff (!rst_n)
      ce && locked && delay != '0 && delay < HALF
      && phase == (STEPS - delay) |=> mem_clk[0] && !core_clk)
      else $error("memory clock not ahead of core by delay");
   a_phase_wrap: assert property ( // see R2
      @(posedge clk) disable iff (!rst_n)
      ce && phase == LAST |=> phase == '0)
      else $error("period not 128 steps");
   a_core_low_half: assert property ( // see R2
      @(posedge clk) disable iff (!rst_n)
      ce && phase == HALF |=> !core_clk)
      else $error("core clock high past half period");
   a_mode_free: assert property ( // see R6
      @(posedge clk) disable iff (!rst_n)
      ce |=> mem_clk[0] == $past(shift_lvl))
      else $error("memory clock depends on mode");
   a_lock_needs_meas: assert property ( // see R10
      @(posedge clk) disable iff (!rst_n)
      $rose(locked) |-> measured && $past(state == CSD_ST_LOCK))
      else $error("locked before a measurement");
   a_acq_unlocked: assert property ( // see R10
      @(posedge clk) disable iff (!rst_n)
      state == CSD_ST_ACQ |-> !locked && !measured)
      else $error("locked while still acquiring");
   a_lock_stays: assert property ( // see R10
      @(posedge clk) disable iff (!rst_n)
      locked |=> locked)
      else $error("lock dropped without reset");
   a_hold_delay: assert property ( // see R10
      @(posedge clk) disable iff (!rst_n)
      state == CSD_ST_HOLD |=> delay == $past(delay))
      else $error("delay moved during hold");
   a_meas_applied: assert property ( // see R3
      @(posedge clk) disable iff (!rst_n)
      ce && mif.done && state != CSD_ST_HOLD |=> delay == $past(mif.steps))
      else $error("measured steps not applied");
   a_start_edge: assert property ( // see R3
      @(posedge clk) disable iff (!rst_n)
      mif.start |=> fb_out)
      else $error("feedback edge not sent at measurement start");
   a_outputs_set: assert property ( // see R1
      @(posedge clk) disable iff (!rst_n)
      ce |=> core_clk == $past(core_lvl))
      else $error("core clock output wrong");
endmodule : csd_clock_synth
`default_nettype wire

// *** csd_pkg.sv ***
// shared constants of the clock synthesiser with feedback delay loop
// assumes one system clock; one delay step is one system clock cycle
package csd_pkg;
   localparam int unsigned CSD_STEPS      = 128;   // delay steps per period
   localparam int unsigned CSD_STEP_W     = 7;     // bits of a step count
   localparam int unsigned CSD_HOLD_PER   = 1;     // periods held before lock
   localparam int unsigned CSD_N_CPU      = 3;     // two processors, one slave
   localparam int unsigned CSD_N_MEM      = 4;
   localparam int unsigned CSD_N_PCI      = 5;
   localparam logic [6:0]  CSD_PHASE_RST  = 7'h00;
   localparam logic [6:0]  CSD_DELAY_RST  = 7'h00;

   typedef enum logic [2:0] {
      CSD_ST_ACQ  = 3'b001,
      CSD_ST_HOLD = 3'b010,
      CSD_ST_LOCK = 3'b100
   } csd_state_t;
endpackage : csd_pkg

// *** csd_meas_if.sv ***
// carrier between loop control and the feedback measurement unit
// assumes both ends share clk
`timescale 1ns/1ps
`default_nettype none
interface csd_meas_if #(
   parameter int unsigned W = 7
);
   logic         start;
   logic         done;
   logic [W-1:0] steps;

   modport ctl  (output start, input  done, input  steps);
   modport meas (input  start, output done, output steps);
endinterface : csd_meas_if
`default_nettype wire

// *** csd_meas.sv ***
// feedback delay measurement: counts steps from a start pulse to the
// first rising edge on the feedback input
// assumes fb_in is synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module csd_meas #(
   parameter int unsigned W = 7
) (
   input  wire logic  clk,
   input  wire logic  rst_n,
   input  wire logic  ce,
   input  wire logic  fb_in,
   csd_meas_if.meas   m
);
   localparam logic [W-1:0] CNT_MAX = '1;

   logic         busy;
   logic         fb_prev;
   logic [W-1:0] cnt;
   logic         done;
   logic [W-1:0] steps;
   logic         next_busy;
   logic         next_fb_prev;
   logic [W-1:0] next_cnt;
   logic         next_done;
   logic [W-1:0] next_steps;

   always_comb begin
      next_busy    = busy;
      next_fb_prev = fb_in;
      next_cnt     = cnt;
      next_done    = 1'b0;
      next_steps   = steps;
      if (m.start) begin
         next_busy = 1'b1;
         next_cnt  = '0;
      end else if (busy) begin
         // a lost echo saturates at one step short of a full period
         if ((fb_in && !fb_prev) || cnt == CNT_MAX) begin  // see R3
            next_busy  = 1'b0;
            next_done  = 1'b1;
            next_steps = cnt;
         end else begin
            next_cnt = W'(cnt + 1'b1);
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy    <= 1'b0;
         fb_prev <= 1'b0;
         cnt     <= '0;
         done    <= 1'b0;
         steps   <= '0;
      end else if (ce) begin
         busy    <= next_busy;
         fb_prev <= next_fb_prev;
         cnt     <= next_cnt;
         done    <= next_done;
         steps   <= next_steps;
      end
   end

   assign m.done  = done && ce;
   assign m.steps = steps;

   a_meas_done_ends: assert property ( // see R3
      @(posedge clk) disable iff (!rst_n)
      (ce && busy && !m.start && fb_in && !fb_prev)
      |=> (done && steps == $past(cnt)))
      else $error("echo edge not turned into a result");
endmodule : csd_meas
`default_nettype wire

// *** csd_board.sv ***
// board model: feedback trace from fb_out back to fb_in
// assumes shared clk; trace delay counted in whole clk cycles
`timescale 1ns/1ps
`default_nettype none
module csd_board (
   input  wire logic       clk,
   input  wire logic       fb_out,
   input  wire logic [4:0] trace_delay,
   output logic            fb_in
);
   logic [31:0] line = 32'h0000_0000;
   // a longer trace only delays the echo, it never reshapes it
   always @(posedge clk) begin
      line <= {line[30:0], fb_out};
   end
   assign fb_in = line[trace_delay];
endmodule : csd_board
`default_nettype wire

// *** tb_top.sv ***
// top bench: clock synthesiser with board trace model, self-checking
// assumes csd_board echoes fb_out after trace_delay+1 cycles
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   logic       ce = 1'b1;
   logic       host_mode = 1'b1;
   logic       alias_in = 1'b0;
   logic [4:0] trace_delay = 5'h07;
   logic       fb_in, fb_out, core_clk, locked, hm_d;
   logic [2:0] cpu_clk;
   logic [3:0] mem_clk;
   logic [4:0] pci_clk;
   logic [6:0] delay_steps;
   int         n_errors = 0;
   int         n_checks = 0;
   int         cnt = 0;
   int         t0, t1, d0;

   csd_clock_synth csd_clock_synth_inst (.clk(clk), .rst_n(rst_n),
      .ce(ce), .host_mode(host_mode), .core_clock_input_alias(alias_in),
      .fb_in(fb_in), .fb_out(fb_out), .core_clk(core_clk),
      .cpu_clk(cpu_clk), .mem_clk(mem_clk), .pci_clk(pci_clk),
      .delay_steps(delay_steps), .locked(locked));
   csd_board csd_board_inst (.clk(clk), .fb_out(fb_out),
      .trace_delay(trace_delay), .fb_in(fb_in));

   initial begin
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cnt <= cnt + 1;
      hm_d <= host_mode;
   end

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : check

   task automatic print_verdict;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : print_verdict

   // bounded wait for a rising level on core_clk or mem_clk[0]
   task automatic rise_of(input logic sel, output int t);
      logic p, c;
      c = 1'b1;
      for (int i = 0; i < 300; i++) begin
         p = c;
         @(negedge clk);
         c = sel ? mem_clk[0] : core_clk;
         if (p === 1'b0 && c === 1'b1) break;
      end
      t = cnt;
      // a missing edge is a timed-out wait, counted as a mismatch
      if (!(p === 1'b0 && c === 1'b1)) n_errors++;
   endtask : rise_of

   // echo returns trace_delay+1 steps after the feedback edge
   task automatic lead_check;
      int exp_d;
      exp_d = int'(trace_delay) + 1;
      rise_of(1'b1, t0);
      rise_of(1'b0, t1);
      check(16'(t1 - t0), 16'(exp_d));
      check({9'h000, delay_steps}, 16'(exp_d));
   endtask : lead_check

   // shifted clocks share one source; fan-out follows the core clock in host mode, idle in agent mode
   always @(negedge clk) begin
      check({13'h0000, cpu_clk}, {13'h0000, {3{mem_clk[0]}}});
      check({11'h000, fb_out, mem_clk}, {11'h000, {5{mem_clk[0]}}});
      if (host_mode === hm_d)
         check(16'(pci_clk), 16'({5{host_mode & core_clk}}));
   end

   task automatic t_reset;
      @(negedge clk);
      check({13'h0000, core_clk, locked, fb_out}, 16'h0000);
      check({4'h0, cpu_clk, mem_clk, pci_clk}, 16'h0000);
      @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      check({3'h0, core_clk, mem_clk, cpu_clk, pci_clk}, 16'h1FFF);
   endtask : t_reset

   task automatic t_lock;
      int i;
      i = 0;
      while (locked !== 1'b1 && i < 1000) begin
         @(negedge clk);
         i++;
      end
      check(16'(i > 128), 16'h0001);
      check({15'h0000, locked}, 16'h0001);
      rise_of(1'b0, t0);
      rise_of(1'b0, t1);
      check(16'(t1 - t0), 16'h0080);
      lead_check;
   endtask : t_lock

   task automatic t_shift;
      d0 = int'(delay_steps);
      trace_delay = 5'h13;
      repeat (384) @(negedge clk);
      check(16'(delay_steps - d0), 16'h000C);
      rise_of(1'b0, t0);
      check(16'((t0 - t1) % 128), 16'h0000);
      lead_check;
   endtask : t_shift

   task automatic t_ce;
      logic [15:0] snap;
      logic [15:0] held;
      ce = 1'b0;
      @(negedge clk);
      snap = {1'b0, core_clk, locked, delay_steps, mem_clk, fb_out, cpu_clk[0]};
      repeat (10) @(negedge clk);
      held = {1'b0, core_clk, locked, delay_steps, mem_clk, fb_out, cpu_clk[0]};
      check(held, snap);
      ce = 1'b1;
   endtask : t_ce

   task automatic t_agent;
      d0 = int'(delay_steps);
      host_mode = 1'b0;
      repeat (384) @(negedge clk);
      check({9'h000, delay_steps}, 16'(d0));
      lead_check;
   endtask : t_agent

   // external source drives the core input directly in agent mode
   task automatic t_alias;
      rise_of(1'b0, t0);
      repeat (80) @(negedge clk);
      alias_in = 1'b1;
      repeat (3) @(negedge clk);
      check({15'h0000, core_clk}, 16'h0001);
      repeat (67) @(negedge clk);
      check({15'h0000, core_clk}, 16'h0000);
      alias_in = 1'b0;
   endtask : t_alias

   initial begin
      t_reset;
      t_lock;
      t_shift;
      t_ce;
      t_agent;
      t_alias;
      print_verdict;
   end

   // whole run is about 2000 cycles; allow well over three times that
   initial begin
      #400000;
      n_errors++;
      print_verdict;
   end
endmodule : tb_top
`default_nettype wire
